// *** pkg/rlr_regs.svh ***
// Opcodes, CDB field positions, sense codes and fixed data lengths
`ifndef RLR_REGS_SVH
`define RLR_REGS_SVH
`define RLR_OP_REL6      8'h17
`define RLR_OP_REL10     8'h57
`define RLR_OP_SA_IN     8'hA3
`define RLR_SA_REP_ID    5'h05
`define RLR_OP_LUN_LIST  8'hA0
`define RLR_TP_BIT       4
`define RLR_SA_MSB       4
`define RLR_B_OP         0
`define RLR_B_FLAGS      1
`define RLR_B_LUN_HI     4
`define RLR_B_LUN_LO     5
`define RLR_B_ALLOC      6
`define RLR_ST_GOOD      8'h00
`define RLR_ST_CHECK     8'h02
`define RLR_SK_NONE      4'h0
`define RLR_SK_NOT_READY 4'h2
`define RLR_SK_ILLEGAL   4'h5
`define RLR_ASC_NONE     8'h00
`define RLR_ASC_NOT_RDY  8'h04
`define RLR_ASC_BAD_OP   8'h20
`define RLR_ASC_BAD_FLD  8'h24
`define RLR_ID_HDR       33'h0_0000_0004
`define RLR_LUN_MIN      32'h0000_0010
`define RLR_LUN_LIST_LEN 8'h08
`define RLR_LUN_LEN_IDX  32'h0000_0003
`endif

// *** pkg/rlr_pkg.sv ***
// Types shared by the command handler
package rlr_pkg;
	typedef enum logic [2:0] {
		RLR_ST_IDLE = 3'b001,
		RLR_ST_SEND = 3'b010,
		RLR_ST_DONE = 3'b100
	} rlr_state_type;
	typedef enum logic [1:0] {
		RLR_K_NONE = 2'b00,
		RLR_K_ID   = 2'b01,
		RLR_K_LUN  = 2'b10
	} rlr_kind_type;
endpackage

// *** core/rlr_cmd.sv ***
// Release, device identifier report and logical unit list command handler
// Notes on behaviour
// - Opcodes 17h and 57h release the unit.
// - Release without reservation: Good, state kept.
// - Third party flag set gives invalid field.
// - Identifier and reservation id bytes ignored.
// - A3h/05h is identifier report; LUN, length.
// - Nonzero LUN in identifier report rejected.
// - Short allocation truncates identifier data silently.
// - Big-endian identifier length, never reduced.
// - Length zero until identifier set succeeds.
// - Identifier kept in external nonvolatile store.
// - Same identifier for every initiator.
// - Store not ready: immediate not ready check.
// - Unit list command A0h accepted whatever the reservation.
// - Unit list allocation below 16 rejected.
// - Unit list returns only entries that fit.
// - List length 8, reserved, one unit zero.
// - Data ends at available or requested count.
`include "rlr_regs.svh"
module rlr_cmd
	import rlr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        cdb_valid,
	output logic             cdb_ready,
	input  wire logic [95:0] cdb_bytes,
	input  wire logic        res_held,
	output logic             res_release,
	input  wire logic        nv_ready,
	input  wire logic [31:0] id_len,
	output logic [31:0]      id_addr,
	input  wire logic [7:0]  id_byte,
	output logic             din_valid,
	input  wire logic        din_ready,
	output logic [7:0]       din_data,
	output logic             din_last,
	output logic             cmd_done,
	output logic [7:0]       cmd_status,
	output logic [3:0]       sense_key,
	output logic [7:0]       sense_asc
);

	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	function automatic logic [7:0] cdb_byte(input logic [95:0] c, input int i);
		cdb_byte = c[95 - 8 * i -: 8];
	endfunction

	// Byte idx of the returned parameter data for the given command kind
	function automatic logic [7:0] byte_at(input rlr_kind_type k,
		input logic [31:0] idx, input logic [31:0] len, input logic [7:0] idb);
		byte_at = 8'h00;
		if (k == RLR_K_ID) begin
			if (idx < 32'h0000_0004)
				byte_at = len[31 - 8 * idx[1:0] -: 8];
			else
				byte_at = idb;
		end else if (k == RLR_K_LUN && idx == `RLR_LUN_LEN_IDX) begin
			byte_at = `RLR_LUN_LIST_LEN;
		end
	endfunction

	// ---------------------------------------------
	// State
	// ---------------------------------------------
	rlr_state_type st_q, st_d;
	rlr_kind_type  kind_q, kind_d;
	logic [31:0]   cnt_q, cnt_d;
	logic [31:0]   lim_q, lim_d;
	logic [7:0]    data_q, data_d;
	logic          rel_q, rel_d;
	logic [7:0]    stat_q, stat_d;
	logic [3:0]    sk_q, sk_d;
	logic [7:0]    asc_q, asc_d;

	logic [7:0]  op;
	logic [7:0]  flags;
	logic [15:0] lun;
	logic [31:0] alloc;
	logic        acc;
	logic        is_rel;
	logic        is_id;
	logic        is_lun;
	logic [31:0] nxt_idx;

	assign op     = cdb_byte(cdb_bytes, `RLR_B_OP);
	assign flags  = cdb_byte(cdb_bytes, `RLR_B_FLAGS);
	assign lun    = {cdb_byte(cdb_bytes, `RLR_B_LUN_HI),
		cdb_byte(cdb_bytes, `RLR_B_LUN_LO)};
	assign alloc  = {cdb_byte(cdb_bytes, `RLR_B_ALLOC),
		cdb_byte(cdb_bytes, `RLR_B_ALLOC + 1),
		cdb_byte(cdb_bytes, `RLR_B_ALLOC + 2),
		cdb_byte(cdb_bytes, `RLR_B_ALLOC + 3)};
	assign acc    = cdb_valid && st_q == RLR_ST_IDLE;
	assign is_rel = op == `RLR_OP_REL6 || op == `RLR_OP_REL10;
	assign is_id  = op == `RLR_OP_SA_IN
		&& flags[`RLR_SA_MSB:0] == `RLR_SA_REP_ID;
	assign is_lun = op == `RLR_OP_LUN_LIST;

	// Index of the byte to show next; the store answers in the same cycle
	always_comb begin
		nxt_idx = 32'h0000_0000;
		if (st_q == RLR_ST_SEND && din_ready)
			nxt_idx = cnt_q + 32'h0000_0001;
	end
	assign id_addr = nxt_idx - 32'h0000_0004;

	// ---------------------------------------------
	// Command sequencing
	// ---------------------------------------------
	always_comb begin
		logic [32:0] avail;
		avail  = 33'h0_0000_0000;
		st_d   = st_q;
		kind_d = kind_q;
		cnt_d  = cnt_q;
		lim_d  = lim_q;
		data_d = data_q;
		rel_d  = 1'b0;
		stat_d = stat_q;
		sk_d   = sk_q;
		asc_d  = asc_q;
		case (st_q)
			RLR_ST_IDLE: begin
				if (cdb_valid) begin
					st_d   = RLR_ST_DONE;
					kind_d = RLR_K_NONE;
					cnt_d  = 32'h0000_0000;
					lim_d  = 32'h0000_0000;
					stat_d = `RLR_ST_GOOD;
					sk_d   = `RLR_SK_NONE;
					asc_d  = `RLR_ASC_NONE;
					// Byte 2 and the device id byte are never looked at
					if (is_rel) begin
						if (flags[`RLR_TP_BIT]) begin
							stat_d = `RLR_ST_CHECK;
							sk_d   = `RLR_SK_ILLEGAL;
							asc_d  = `RLR_ASC_BAD_FLD;
						end else begin
							// Extent bit trusted clear by the host
							rel_d = res_held;
						end
					end else if (is_id) begin
						if (lun != 16'h0000) begin
							stat_d = `RLR_ST_CHECK;
							sk_d   = `RLR_SK_ILLEGAL;
							asc_d  = `RLR_ASC_BAD_FLD;
						end else if (!nv_ready) begin
							stat_d = `RLR_ST_CHECK;
							sk_d   = `RLR_SK_NOT_READY;
							asc_d  = `RLR_ASC_NOT_RDY;
						end else begin
							// Length comes from the shared store, zero until set
							avail  = {1'b0, id_len} + `RLR_ID_HDR;
							kind_d = RLR_K_ID;
							lim_d  = ({1'b0, alloc} < avail) ? alloc
								: avail[31:0];
						end
					end else if (is_lun) begin
						// Reservations are not consulted here
						if (alloc < `RLR_LUN_MIN) begin
							stat_d = `RLR_ST_CHECK;
							sk_d   = `RLR_SK_ILLEGAL;
							asc_d  = `RLR_ASC_BAD_FLD;
						end else begin
							kind_d = RLR_K_LUN;
							lim_d  = `RLR_LUN_MIN;
						end
					end else begin
						stat_d = `RLR_ST_CHECK;
						sk_d   = `RLR_SK_ILLEGAL;
						asc_d  = `RLR_ASC_BAD_OP;
					end
					// A zero length ends at once, keeping the status set by the branch above
					if (lim_d != 32'h0000_0000) begin
						st_d   = RLR_ST_SEND;
						data_d = byte_at(kind_d, 32'h0000_0000, id_len, id_byte);
					end
				end
			end
			RLR_ST_SEND: begin
				if (din_ready) begin
					cnt_d = nxt_idx;
					if (nxt_idx == lim_q)
						st_d = RLR_ST_DONE;
					else
						data_d = byte_at(kind_q, nxt_idx, id_len, id_byte);
				end
			end
			RLR_ST_DONE: begin
				st_d = RLR_ST_IDLE;
			end
			default: begin
				st_d = RLR_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= RLR_ST_IDLE;
			kind_q <= RLR_K_NONE;
			cnt_q  <= 32'h0000_0000;
			lim_q  <= 32'h0000_0000;
			data_q <= 8'h00;
			rel_q  <= 1'b0;
			stat_q <= `RLR_ST_GOOD;
			sk_q   <= `RLR_SK_NONE;
			asc_q  <= `RLR_ASC_NONE;
		end else begin
			st_q   <= st_d;
			kind_q <= kind_d;
			cnt_q  <= cnt_d;
			lim_q  <= lim_d;
			data_q <= data_d;
			rel_q  <= rel_d;
			stat_q <= stat_d;
			sk_q   <= sk_d;
			asc_q  <= asc_d;
		end
	end

	// ---------------------------------------------
	// Outputs
	// ---------------------------------------------
	assign cdb_ready   = st_q == RLR_ST_IDLE;
	assign din_valid   = st_q == RLR_ST_SEND;
	assign din_data    = data_q;
	assign din_last    = din_valid && cnt_q + 32'h0000_0001 == lim_q;
	assign cmd_done    = st_q == RLR_ST_DONE;
	assign res_release = rel_q;
	assign cmd_status  = stat_q;
	assign sense_key   = sk_q;
	assign sense_asc   = asc_q;

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_rel_frees_unit: assert property (
		acc && is_rel && !flags[`RLR_TP_BIT] && res_held
		|=> res_release && cmd_done && cmd_status == `RLR_ST_GOOD
		##1 !res_release)
		else $error("release of held unit not signalled");

	a_rel_no_hold: assert property (
		acc && is_rel && !flags[`RLR_TP_BIT] && !res_held
		|=> !res_release && cmd_done && cmd_status == `RLR_ST_GOOD)
		else $error("release without hold misbehaved");

	a_rel_third_party: assert property (
		acc && is_rel && flags[`RLR_TP_BIT]
		|=> !res_release && cmd_status == `RLR_ST_CHECK
		&& sense_key == `RLR_SK_ILLEGAL && sense_asc == `RLR_ASC_BAD_FLD)
		else $error("third party release not rejected");

	a_id_bad_lun: assert property (
		acc && is_id && lun != 16'h0000
		|=> cmd_done && cmd_status == `RLR_ST_CHECK
		&& sense_asc == `RLR_ASC_BAD_FLD)
		else $error("nonzero lun not rejected");

	a_id_not_ready: assert property (
		acc && is_id && lun == 16'h0000 && !nv_ready
		|=> cmd_done && !din_valid && sense_key == `RLR_SK_NOT_READY)
		else $error("store not ready not reported at once");

	a_id_len_bytes: assert property (
		din_valid && kind_q == RLR_K_ID && cnt_q == 32'h0000_0000
		|-> din_data == $past(id_len[31:24], 1) || $past(!cdb_valid, 1))
		else $error("identifier length byte wrong");

	a_lun_short: assert property (
		acc && is_lun && alloc < `RLR_LUN_MIN
		|=> cmd_done && cmd_status == `RLR_ST_CHECK)
		else $error("short unit list allocation accepted");

	a_lun_good: assert property (
		acc && is_lun && alloc >= `RLR_LUN_MIN
		|=> din_valid && cmd_status == `RLR_ST_GOOD)
		else $error("unit list not started");

	a_lun_len_byte: assert property (
		din_valid && kind_q == RLR_K_LUN
		|-> din_data == ((cnt_q == `RLR_LUN_LEN_IDX) ? `RLR_LUN_LIST_LEN : 8'h00))
		else $error("unit list byte wrong");

	a_send_bound: assert property (
		din_valid && din_ready && din_last |=> cmd_done && !din_valid)
		else $error("data phase did not end at limit");

	a_zero_alloc: assert property (
		acc && is_id && lun == 16'h0000 && nv_ready && alloc == 32'h0000_0000
		|=> cmd_done && cmd_status == `RLR_ST_GOOD)
		else $error("zero allocation not ended cleanly");

	c_release: cover property (acc && is_rel ##1 res_release);
	c_id_full: cover property (din_valid && kind_q == RLR_K_ID && din_last);
	c_lun_list: cover property (acc && is_lun ##[1:20] cmd_done);

endmodule

// *** verif/rlr_host_model.sv ***
// Host side model: data-in sink with optional stalls and the identifier store
module rlr_host_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        stall_en,
	input  wire logic [31:0] id_addr,
	output logic [7:0]       id_byte,
	output logic             din_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	// One stored pattern answers every request, whichever initiator asks
	assign id_byte = id_addr[7:0] ^ 8'h5A;
	// Random stalls drop ready on about one cycle in three, holding the design's data bytes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			din_ready <= 1'b0;
		else
			din_ready <= stall_en ? 1'(($urandom % 3) != 0) : 1'b1;
	end
endmodule

// *** verif/rlr_cmd_tb_top.sv ***
// Self-checking bench for the release, identifier and unit list handler
module rlr_cmd_tb_top
	import rlr_pkg::*;
;
	timeunit 1ns;
	// Finer precision keeps the 12.5 ns half period exact
	timeprecision 100ps;
	logic clk = 1'b0, rst_n = 1'b0, cdb_valid = 1'b0, res_held = 1'b0;
	logic nv_ready = 1'b1, din_ready, stall_en = 1'b0;
	logic [95:0] cdb_bytes = 96'h0;
	logic [31:0] id_len = 32'h0000_0000, id_addr;
	logic [7:0] id_byte, din_data, cmd_status, sense_asc;
	logic [3:0] sense_key;
	logic cdb_ready, res_release, din_valid, din_last, cmd_done;
	logic [21:0] q[$];
	int fails = 0, n_tests = 0, cyc = 0;
	always #12.5 clk = ~clk;
	rlr_cmd i_dut (.clk(clk), .rst_n(rst_n), .cdb_valid(cdb_valid), .cdb_ready(cdb_ready),
		.cdb_bytes(cdb_bytes), .res_held(res_held), .res_release(res_release),
		.nv_ready(nv_ready), .id_len(id_len), .id_addr(id_addr), .id_byte(id_byte),
		.din_valid(din_valid), .din_ready(din_ready), .din_data(din_data),
		.din_last(din_last), .cmd_done(cmd_done), .cmd_status(cmd_status),
		.sense_key(sense_key), .sense_asc(sense_asc));
	rlr_host_model i_host (.clk(clk), .rst_n(rst_n), .stall_en(stall_en), .id_addr(id_addr),
		.id_byte(id_byte), .din_ready(din_ready));
	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic end_of_test();
		if (q.size() != 0)
			fails++;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [21:0] got);
		logic [21:0] exp;
		n_tests++;
		exp = (q.size() > 0) ? q.pop_front() : 22'h3F_FFFF;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Sampled mid-cycle so the edge's own updates have settled
	always @(negedge clk) begin
		if (din_valid === 1'b1 && din_ready === 1'b1)
			chk({1'b1, 12'h000, din_last, din_data});
		if (cmd_done === 1'b1)
			chk({1'b0, res_release, cmd_status, sense_key, sense_asc});
		// Ready is up while a command is offered and down while one runs
		if (cdb_valid === 1'b1 || din_valid === 1'b1 || cmd_done === 1'b1) begin
			n_tests++;
			if (cdb_ready !== (cdb_valid === 1'b1)) begin
				fails++;
				$display("wrong value at %0t: got %h expected %h", $time, cdb_ready,
					cdb_valid === 1'b1);
			end
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	task automatic xs(input logic [95:0] c, input logic [21:0] st);
		q.push_back(st);
		cdb_bytes <= c;
		cdb_valid <= 1'b1;
		@(posedge clk);
		cdb_valid <= 1'b0;
		cdb_bytes <= {$urandom, $urandom, $urandom};
		do @(negedge clk); while (cmd_done !== 1'b1);
		@(posedge clk);
	endtask
	task automatic rel(input logic [7:0] op, input logic tp, input logic held);
		logic [31:0] r;
		logic [7:0] b1;
		r = $urandom;
		b1 = {3'b000, tp, (op == 8'h17) ? r[3:1] : 3'b000, 1'b0};
		res_held <= held;
		xs({op, b1, r[15:8], r[23:16], 64'h0000_0000_0000_0000},
			tp ? {2'b00, 8'h02, 4'h5, 8'h24} : {1'b0, held, 20'h0_0000});
	endtask
	task automatic idrep(input logic [31:0] al, input logic [31:0] ln);
		logic [31:0] lim;
		logic [31:0] k;
		lim = (al < ln + 32'h0000_0004) ? al : ln + 32'h0000_0004;
		for (int i = 0; i < lim; i++) begin
			k = i - 4;
			q.push_back({1'b1, 12'h000, 1'(i == lim - 1),
				(i < 4) ? ln[31 - 8 * i -: 8] : k[7:0] ^ 8'h5A});
		end
		id_len <= ln;
		xs({8'hA3, 8'h05, 32'h0000_0000, al, 16'h0000}, 22'h00_0000);
	endtask
	task automatic lunrep(input logic [31:0] al);
		if (al < 32'h0000_0010) begin
			xs({8'hA0, 40'h00_0000_0000, al, 16'h0000}, {2'b00, 8'h02, 4'h5, 8'h24});
		end else begin
			for (int i = 0; i < 16; i++)
				q.push_back({1'b1, 12'h000, 1'(i == 15), (i == 3) ? 8'h08 : 8'h00});
			xs({8'hA0, 40'h00_0000_0000, al, 16'h0000}, 22'h00_0000);
		end
	endtask
	initial begin
		logic [31:0] lens [4];
		lens = '{32'h0000_0000, 32'h0000_000F, 32'h0000_0010, 32'h0000_1000};
		void'($urandom(92));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 4; k++)
			rel(k[0] ? 8'h57 : 8'h17, 1'b0, k[1]);
		rel(8'h17, 1'b1, 1'b1);
		rel(8'h57, 1'b1, 1'b0);
		nv_ready <= 1'b0;
		xs({8'hA3, 8'h05, 32'h0000_0000, 32'h0000_0008, 16'h0000}, {2'b00, 8'h02, 4'h2, 8'h04});
		nv_ready <= 1'b1;
		xs({8'hA3, 8'h05, 16'h0000, 16'h0001, 32'h0000_0008, 16'h0000},
			{2'b00, 8'h02, 4'h5, 8'h24});
		xs({8'h12, 88'h0}, {2'b00, 8'h02, 4'h5, 8'h20});
		xs({8'hA3, 8'h0C, 80'h0}, {2'b00, 8'h02, 4'h5, 8'h20});
		idrep(32'h0000_0002, 32'h0000_0005);
		idrep(32'h0000_0028, 32'h0000_0000);
		for (int k = 0; k < 12; k++) begin
			stall_en <= k[0];
			idrep($urandom % 24, $urandom % 12);
		end
		res_held <= 1'b1;
		for (int k = 0; k < 4; k++)
			lunrep(lens[k]);
		repeat (4) @(posedge clk);
		end_of_test();
	end
endmodule
